// [test_ulm_top.sv]
// Purpose: self-checking bench for the serial mode control block.
// Assumes: BASE_DIV of 1 and the reset bit time of 16 base ticks.
// Notes: every wait is bounded; a spent bound ends the run as a failure.
`timescale 1ns/1ps
`include "ulm_map.svh"
module test_ulm_top
  import ulm_pkg::*;
;
  logic clk_i, rst_i, we_i, stb_i, cyc_i, ack_o, rx_pin, tx_pin, done_irq, err_irq;
  logic [17:0] adr_i;
  logic [31:0] dat_i, dat_o;
  logic [3:0] sel_i, cap_cnt;
  logic [23:0] cap;
  int errors = 0;
  int total_checks = 0;
  int done_cnt = 0;
  int err_cnt = 0;
  ulm_top #(.BASE_DIV(1)) ulm_top_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i),
    .ack_o(ack_o), .serial_rx_pin_i(rx_pin), .serial_tx_pin_o(tx_pin),
    .rx_done_irq_o(done_irq), .rx_error_irq_o(err_irq));
  ulm_remote #(.BIT_CLKS(16)) ulm_remote_i (.clk_i(clk_i), .serial_tx_pin_i(tx_pin),
    .serial_rx_pin_o(rx_pin), .cap_o(cap), .cap_cnt_o(cap_cnt));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (done_irq === 1'b1)
      done_cnt <= done_cnt + 1;
    if (err_irq === 1'b1)
      err_cnt <= err_cnt + 1;
  end
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    errors++;
    wrap_up();
  endtask
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_i);
    end
    if (ack_o !== 1'b1)
      tmo();
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk(q, {24'h0, e});
  endtask
  // Start bit, data LSB first, optional parity; unused positions stay high.
  function automatic logic [15:0] frame(input logic [7:0] d, input logic [4:0] c);
    logic [15:0] f;
    logic p;
    int k;
    f = 16'hFFFF;
    f[0] = 1'b0;
    k = 1;
    p = ^(c[2] ? d : (d & 8'h7F));
    for (int i = 0; i < (c[2] ? 8 : 7); i++)
    begin
      f[k] = d[i];
      k++;
    end
    if (c[4:3] != 2'h0)
      f[k] = (c[4:3] == 2'h1) ? 1'b0 : ((c[4:3] == 2'h2) ? ~p : p);
    return f;
  endfunction
  task automatic reset_case();
    int d0;
    rd(`ULM_IDX_MODE, `ULM_MODE_RST);
    rd(`ULM_IDX_PROTO, 8'h00);
    rd(`ULM_IDX_RXBUF, `ULM_RXBUF_RST);
    rd(16'h0000, 8'h00);
    d0 = done_cnt + err_cnt;
    ulm_remote_i.send(16'h0000, 12);
    repeat (20) @(posedge clk_i);
    chk(done_cnt + err_cnt - d0, 0);
    chk(tx_pin, 1'b1);
  endtask
  task automatic tx_case(input logic [4:0] c, input logic [7:0] d1, input logic [7:0] d2,
    input int n);
    logic [31:0] q;
    logic [23:0] e;
    logic [3:0] k0;
    int t;
    wr(`ULM_IDX_MODE, {3'h4, c});
    wr(`ULM_IDX_MODE, {3'h6, c});
    k0 = cap_cnt;
    wr(`ULM_IDX_TXBUF, d1);
    wr(`ULM_IDX_MODE, {3'h6, c});
    t = 0;
    q = 32'h2;
    while (q[1] !== 1'b0 && t < 400)
    begin
      wb(1'b0, `ULM_IDX_TXST, 8'h00, q);
      t++;
    end
    if (q[1] !== 1'b0)
      tmo();
    chk(q, 32'h1);
    wr(`ULM_IDX_TXBUF, d2);
    // The first frame is still on the line, so the second byte waits in the buffer.
    rd(`ULM_IDX_TXST, 8'h03);
    t = 0;
    while (cap_cnt === k0 && t < 2000)
    begin
      t++;
      @(posedge clk_i);
    end
    if (cap_cnt === k0)
      tmo();
    e = ({8'hFF, frame(d2, c)} << n) | ({8'h00, frame(d1, c)} & ((24'h1 << n) - 24'h1));
    chk(cap, e);
    wr(`ULM_IDX_MODE, {3'h4, c});
    wr(`ULM_IDX_MODE, {3'h0, c});
  endtask
  task automatic rx_case(input logic [4:0] c, input logic p, input logic [15:0] f,
    input int n, input logic [15:0] idx, input logic [7:0] d, input int ed, input int ee,
    input logic [7:0] er);
    int d0;
    int e0;
    wr(`ULM_IDX_PROTO, {7'h0, p});
    wr(`ULM_IDX_MODE, {3'h4, c});
    wr(`ULM_IDX_MODE, {3'h5, c});
    d0 = done_cnt;
    e0 = err_cnt;
    ulm_remote_i.send(f, n);
    repeat (3) @(posedge clk_i);
    chk(done_cnt - d0, ed);
    chk(err_cnt - e0, ee);
    if (er !== 8'hFF)
      rd(`ULM_IDX_ERR, er);
    rd(idx, d);
    wr(`ULM_IDX_MODE, {3'h4, c});
    // Powered but with reception off, a full frame on the line must be ignored.
    d0 = done_cnt + err_cnt;
    ulm_remote_i.send(f, n);
    repeat (20) @(posedge clk_i);
    chk(done_cnt + err_cnt - d0, 0);
    wr(`ULM_IDX_MODE, {3'h0, c});
    rd(`ULM_IDX_ERR, 8'h00);
    rd(idx, 8'hFF);
  endtask
  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 18'h0;
    dat_i = 32'h0;
    sel_i = 4'hF;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    reset_case();
    tx_case(5'b00100, 8'hA5, 8'h3C, 10);
    tx_case(5'b01110, 8'hA5, 8'h3C, 12);
    tx_case(5'b10000, 8'h5A, 8'h33, 10);
    tx_case(5'b11110, 8'h96, 8'h01, 12);
    rx_case(5'b11100, 1'b0, frame(8'h96, 5'b11100), 11, `ULM_IDX_RXBUF, 8'h96, 1, 0,
      8'h00);
    rx_case(5'b10100, 1'b0, frame(8'h96, 5'b10100) ^ 16'h0200, 11, `ULM_IDX_RXBUF, 8'h96,
      0, 1, 8'h04);
    rx_case(5'b10101, 1'b0, frame(8'h96, 5'b10101) ^ 16'h0200, 11, `ULM_IDX_RXBUF, 8'h96,
      1, 0, 8'hFF);
    rx_case(5'b01100, 1'b0, frame(8'h96, 5'b01100) ^ 16'h0200, 11, `ULM_IDX_RXBUF, 8'h96,
      1, 0, 8'h00);
    rx_case(5'b00010, 1'b0, frame(8'h5A, 5'b00010) & 16'hFDFF, 10, `ULM_IDX_RXBUF, 8'h5A,
      1, 0, 8'h00);
    rx_case(5'b10000, 1'b1, {7'h7F, 8'hA3, 1'b0}, 10, `ULM_IDX_LWLO, 8'hC5, 1, 0,
      8'h00);
    wrap_up();
  end
endmodule // test_ulm_top

// [ulm_map.svh]
// What this block does
// - Protocol select bit 0: 0 plain serial, 1 lighting-control framing.
// - Operation mode register loads 01H on reset.
// - Power bit low stops the base clock and resets the internal circuit.
// - Transmit enable low disables and synchronously resets the transmitter.
// - Receive enable low disables and synchronously resets the receiver.
// - Unpowered: transmit pin driven high, receive input seen as high.
// - Power off resets error status, transmit status and receive buffers.
// - Parity field: none, zero, odd or even parity.
// - Zero parity is never checked, so no parity error arises.
// - Length bit selects 7 or 8 data bits both ways.
// - Stop select gives one or two transmitted stop bits.
// - Receiver always expects exactly one stop bit.
// - Error goes to error interrupt if routing bit is 0, else completion.
// - Enabling reception while the line is low starts a reception at once.
// - Enables are sampled on base ticks; wait two base clocks before re-enabling.
// - Lighting mode ignores the parity field and the length bit.
// - Rewriting the mode register with its value leaves transfers undisturbed.
// - Clearing power or receive enable clears the error status register.
// Purpose: register map and field positions of the serial mode control block.
// Assumes: word-indexed register map, byte address is four times the index.
// Notes: definitions only.
`ifndef ULM_MAP_SVH
`define ULM_MAP_SVH
`define ULM_IDX_MODE 16'hFF50
`define ULM_IDX_RXBUF 16'hFF51
`define ULM_IDX_TXBUF 16'hFF52
`define ULM_IDX_ERR 16'hFF53
`define ULM_IDX_TXST 16'hFF55
`define ULM_IDX_BAUD 16'hFF57
`define ULM_IDX_LWLO 16'hFF58
`define ULM_IDX_LWHI 16'hFF59
`define ULM_IDX_PROTO 16'hFF5B
`define ULM_MODE_RST 8'h01
`define ULM_PROTO_RST 1'h0
`define ULM_BAUD_RST 8'h10
`define ULM_RXBUF_RST 8'hFF
`define ULM_LW_RST 16'hFFFF
`define ULM_TXBUF_RST 8'hFF
`define ULM_B_POWER 7
`define ULM_B_TXEN 6
`define ULM_B_RXEN 5
`define ULM_B_PARHI 4
`define ULM_B_PARLO 3
`define ULM_B_CLEN 2
`define ULM_B_STOP 1
`define ULM_B_ROUTE 0
`define ULM_E_PAR 2
`define ULM_E_FRM 1
`define ULM_E_OVR 0
`endif

// [ulm_pkg.sv]
// Purpose: state types of the serial mode control block.
// Assumes: nothing beyond the map header.
// Notes: Gray codes along the normal frame path.
package ulm_pkg;
  typedef enum logic [2:0] {
    ULM_IDLE = 3'h0,
    ULM_START = 3'h1,
    ULM_DATA = 3'h3,
    ULM_PAR = 3'h2,
    ULM_STOP = 3'h6,
    ULM_STOP2 = 3'h7
  } ulm_state_t;
endpackage

// [ulm_remote.sv]
// Purpose: remote serial node facing the transmit and receive pins.
// Assumes: one bit lasts BIT_CLKS clocks and both lines idle high.
// Notes: the captured window is fixed, so a slow second frame shows as a mismatch.
`timescale 1ns/1ps
module ulm_remote
#(
  parameter int BIT_CLKS = 16
)
(
  // Clock.
  input wire logic clk_i,
  // Serial lines.
  input wire logic serial_tx_pin_i,
  output logic serial_rx_pin_o,
  // Captured transmit bits.
  output logic [23:0] cap_o,
  output logic [3:0] cap_cnt_o
);
  initial serial_rx_pin_o = 1'b1;
  initial cap_cnt_o = 4'h0;
  // Bit 0 of the vector goes on the line first; the line returns high after.
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      serial_rx_pin_o <= bits[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    serial_rx_pin_o <= 1'b1;
  endtask
  // Samples at mid-bit so a one-clock launch offset does not matter.
  initial
  begin
    forever
    begin
      @(negedge serial_tx_pin_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i < 24; i++)
      begin
        cap_o[i] = serial_tx_pin_i;
        repeat (BIT_CLKS) @(posedge clk_i);
      end
      cap_cnt_o = cap_cnt_o + 4'h1;
    end
  end
endmodule // ulm_remote

// [ulm_top.sv]
// Purpose: serial unit mode control, transmitter and receiver, Wishbone slave.
// Assumes: one 50 MHz clock, synchronous active-high reset, inputs synchronous.
// Notes: Manchester coding is outside this block; lighting mode fixes 8 data bits and no parity.
`timescale 1ns/1ps
`include "ulm_map.svh"
module ulm_top
  import ulm_pkg::*;
#(
  parameter int BASE_DIV = 1
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic [17:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  output logic ack_o,
  // Serial line.
  input wire logic serial_rx_pin_i,
  output logic serial_tx_pin_o,
  // Interrupt pulses.
  output logic rx_done_irq_o,
  output logic rx_error_irq_o
);

  function automatic logic par_calc(input logic [7:0] d, input logic len8,
                                    input logic [1:0] ps);
    logic x;
    x = ^(len8 ? d : {1'b0, d[6:0]});
    case (ps)
      2'b10: par_calc = ~x;
      2'b11: par_calc = x;
      default: par_calc = 1'b0;
    endcase
  endfunction

  function automatic logic bit_done(input logic [7:0] cnt, input logic [7:0] div);
    bit_done = ({1'b0, cnt} + 9'h001) >= {1'b0, div};
  endfunction

  logic [7:0] op_mode;
  logic proto_sel;
  logic [7:0] baud_div;
  logic [7:0] tx_buf;
  logic [7:0] rx_buf;
  logic [15:0] lw_buf;
  logic [2:0] err_stat;
  logic txb_full;
  logic rxb_full;
  logic [15:0] idx;
  logic wr;
  logic rd;
  logic pwr;
  logic light;
  logic len8;
  logic [1:0] ps;
  logic [3:0] nbits;
  logic [7:0] base_cnt;
  logic base_tick;
  logic tx_en_s;
  logic rx_en_s;
  ulm_state_t tx_state;
  logic [7:0] tx_bcnt;
  logic [3:0] tx_cnt;
  logic [7:0] tx_sh;
  logic tx_par;
  logic tx_load;
  logic tx_end;
  ulm_state_t rx_state;
  logic [7:0] rx_bcnt;
  logic [3:0] rx_cnt;
  logic [7:0] rx_sh;
  logic rx_par;
  logic rx_line;
  logic rx_end;
  logic fdone;
  logic [2:0] new_err;

  assign idx = adr_i[17:2];
  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd = cyc_i && stb_i && !we_i && !ack_o;
  assign pwr = op_mode[`ULM_B_POWER];
  assign light = proto_sel;
  assign len8 = light || op_mode[`ULM_B_CLEN];
  assign ps = light ? 2'b00 : op_mode[`ULM_B_PARHI:`ULM_B_PARLO];
  assign nbits = len8 ? 4'h8 : 4'h7;
  assign rx_line = pwr ? serial_rx_pin_i : 1'b1;

  always_ff @(posedge clk_i)
  begin
    ack_o <= !rst_i && cyc_i && stb_i && !ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0;
    else if (rd)
      case (idx)
        `ULM_IDX_MODE: dat_o <= {24'h0, op_mode};
        `ULM_IDX_PROTO: dat_o <= {31'h0, proto_sel};
        `ULM_IDX_RXBUF: dat_o <= {24'h0, rx_buf};
        `ULM_IDX_TXBUF: dat_o <= {24'h0, tx_buf};
        `ULM_IDX_ERR: dat_o <= {29'h0, err_stat};
        `ULM_IDX_TXST: dat_o <= {30'h0, txb_full && !light, (tx_state != ULM_IDLE) && !light};
        `ULM_IDX_BAUD: dat_o <= {24'h0, baud_div};
        `ULM_IDX_LWLO: dat_o <= {24'h0, lw_buf[7:0]};
        `ULM_IDX_LWHI: dat_o <= {24'h0, lw_buf[15:8]};
        default: dat_o <= 32'h0;
      endcase
  end

  // A write of the current value changes no level, so frames in flight continue.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_mode <= `ULM_MODE_RST;
      proto_sel <= `ULM_PROTO_RST;
      baud_div <= `ULM_BAUD_RST;
    end
    else if (wr)
      case (idx)
        `ULM_IDX_MODE: op_mode <= dat_i[7:0];
        `ULM_IDX_PROTO: proto_sel <= dat_i[0];
        `ULM_IDX_BAUD: baud_div <= dat_i[7:0];
        default: ;
      endcase
  end

  // The base clock stands still while unpowered, which halts every bit timer.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !pwr)
      base_cnt <= 8'h0;
    else if (base_tick)
      base_cnt <= 8'h0;
    else
      base_cnt <= base_cnt + 8'h1;
  end
  assign base_tick = pwr && ({24'h0, base_cnt} >= (BASE_DIV - 1));

  // Enables are sampled on base ticks, so a short pulse low may be missed.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !pwr)
    begin
      tx_en_s <= 1'b0;
      rx_en_s <= 1'b0;
    end
    else if (base_tick)
    begin
      tx_en_s <= op_mode[`ULM_B_TXEN];
      rx_en_s <= op_mode[`ULM_B_RXEN];
    end
  end

  assign tx_load = (tx_state == ULM_IDLE) && txb_full && base_tick;
  assign tx_end = base_tick && bit_done(tx_bcnt, baud_div);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !pwr || !op_mode[`ULM_B_TXEN])
    begin
      tx_buf <= `ULM_TXBUF_RST;
      txb_full <= 1'b0;
    end
    else if (wr && idx == `ULM_IDX_TXBUF && tx_en_s)
    begin
      tx_buf <= dat_i[7:0];
      txb_full <= 1'b1;
    end
    else if (tx_load)
      txb_full <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !tx_en_s)
    begin
      tx_state <= ULM_IDLE;
      tx_bcnt <= 8'h0;
      tx_cnt <= 4'h0;
      tx_sh <= 8'h0;
      tx_par <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_state <= ULM_START;
      tx_bcnt <= 8'h0;
      tx_sh <= tx_buf;
      tx_par <= par_calc(tx_buf, len8, ps);
    end
    else if (base_tick)
    begin
      tx_bcnt <= tx_end ? 8'h0 : tx_bcnt + 8'h1;
      if (tx_end)
        case (tx_state)
          ULM_START:
          begin
            tx_state <= ULM_DATA;
            tx_cnt <= 4'h0;
          end
          ULM_DATA:
          begin
            tx_sh <= light ? {tx_sh[6:0], 1'b0} : {1'b0, tx_sh[7:1]};
            tx_cnt <= tx_cnt + 4'h1;
            if (tx_cnt + 4'h1 == nbits)
              tx_state <= (ps == 2'b00) ? ULM_STOP : ULM_PAR;
          end
          ULM_PAR: tx_state <= ULM_STOP;
          ULM_STOP: tx_state <= op_mode[`ULM_B_STOP] ? ULM_STOP2 : ULM_IDLE;
          default: tx_state <= ULM_IDLE;
        endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !pwr)
      serial_tx_pin_o <= 1'b1;
    else
      case (tx_state)
        ULM_START: serial_tx_pin_o <= 1'b0;
        ULM_DATA: serial_tx_pin_o <= light ? tx_sh[7] : tx_sh[0];
        ULM_PAR: serial_tx_pin_o <= tx_par;
        default: serial_tx_pin_o <= 1'b1;
      endcase
  end

  // Start is found on the first low base tick, even straight after enabling.
  assign rx_end = base_tick && bit_done(rx_bcnt, baud_div);
  assign fdone = base_tick && rx_state == ULM_STOP && bit_done(rx_bcnt, baud_div);
  always_comb
  begin
    new_err = 3'h0;
    if (fdone)
    begin
      new_err[`ULM_E_FRM] = !rx_line;
      new_err[`ULM_E_PAR] = ps[1] && (rx_par != par_calc(rx_sh, len8, ps));
      new_err[`ULM_E_OVR] = rxb_full;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !rx_en_s)
    begin
      rx_state <= ULM_IDLE;
      rx_bcnt <= 8'h0;
      rx_cnt <= 4'h0;
      rx_sh <= 8'h0;
      rx_par <= 1'b0;
    end
    else if (base_tick)
      case (rx_state)
        ULM_IDLE:
        begin
          rx_bcnt <= 8'h0;
          if (!rx_line)
            rx_state <= ULM_START;
        end
        ULM_START:
        begin
          rx_bcnt <= rx_bcnt + 8'h1;
          if (bit_done(rx_bcnt, {1'b0, baud_div[7:1]}))
          begin
            rx_bcnt <= 8'h0;
            rx_cnt <= 4'h0;
            rx_state <= rx_line ? ULM_IDLE : ULM_DATA;
          end
        end
        ULM_DATA:
        begin
          rx_bcnt <= rx_end ? 8'h0 : rx_bcnt + 8'h1;
          if (rx_end)
          begin
            if (light)
              rx_sh <= {rx_sh[6:0], rx_line};
            else if (len8)
              rx_sh <= {rx_line, rx_sh[7:1]};
            else
              rx_sh <= {1'b0, rx_line, rx_sh[6:1]};
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt + 4'h1 == nbits)
              rx_state <= (ps == 2'b00) ? ULM_STOP : ULM_PAR;
          end
        end
        ULM_PAR:
        begin
          rx_bcnt <= rx_end ? 8'h0 : rx_bcnt + 8'h1;
          if (rx_end)
          begin
            rx_par <= rx_line;
            rx_state <= ULM_STOP;
          end
        end
        ULM_STOP:
        begin
          rx_bcnt <= rx_end ? 8'h0 : rx_bcnt + 8'h1;
          if (rx_end)
            rx_state <= ULM_IDLE;
        end
        default: rx_state <= ULM_IDLE;
      endcase
  end

  // A flag raised in the same cycle as a status read survives the read.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !pwr || !op_mode[`ULM_B_RXEN])
      err_stat <= 3'h0;
    else
      err_stat <= ((rd && idx == `ULM_IDX_ERR) ? 3'h0 : err_stat) | new_err;
  end

  // An overrun discards the new character and keeps the unread one.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !pwr)
    begin
      rx_buf <= `ULM_RXBUF_RST;
      lw_buf <= `ULM_LW_RST;
      rxb_full <= 1'b0;
    end
    else
    begin
      if (fdone && !rxb_full)
      begin
        if (light)
          lw_buf <= {lw_buf[7:0], rx_sh};
        else
          rx_buf <= rx_sh;
      end
      if (fdone && !rxb_full)
        rxb_full <= 1'b1;
      else if (rd && (idx == `ULM_IDX_RXBUF || idx == `ULM_IDX_LWLO))
        rxb_full <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_done_irq_o <= 1'b0;
      rx_error_irq_o <= 1'b0;
    end
    else
    begin
      rx_done_irq_o <= fdone && (new_err == 3'h0 || op_mode[`ULM_B_ROUTE]);
      rx_error_irq_o <= fdone && new_err != 3'h0 && !op_mode[`ULM_B_ROUTE];
    end
  end

  mode_reset_a: assert property (@(posedge clk_i) $past(rst_i) |-> op_mode == `ULM_MODE_RST)
    else $error("mode register not at reset value");
  base_stop_a: assert property (@(posedge clk_i) disable iff (rst_i) !pwr |-> !base_tick)
    else $error("base tick while unpowered");
  tx_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !tx_en_s |=> tx_state == ULM_IDLE)
    else $error("transmitter not held in reset");
  rx_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !rx_en_s |=> rx_state == ULM_IDLE)
    else $error("receiver not held in reset");
  tx_high_a: assert property (@(posedge clk_i) disable iff (rst_i) !pwr |=> serial_tx_pin_o)
    else $error("transmit pin low while unpowered");
  power_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pwr |=> rx_buf == `ULM_RXBUF_RST && lw_buf == `ULM_LW_RST && !txb_full)
    else $error("buffers not reset by power off");
  zero_parity_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ps[1] |-> !new_err[`ULM_E_PAR])
    else $error("parity error without parity check");
  two_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_state == ULM_STOP2 |-> op_mode[`ULM_B_STOP])
    else $error("second stop bit not selected");
  irq_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_error_irq_o |-> !$past(op_mode[`ULM_B_ROUTE]) && !rx_done_irq_o)
    else $error("error interrupt misrouted");
  err_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !op_mode[`ULM_B_RXEN] |=> err_stat == 3'h0)
    else $error("error status not cleared");
  irq_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_done_irq_o |=> !rx_done_irq_o)
    else $error("completion interrupt longer than one cycle");

endmodule // ulm_top
